// File: design/psrp_port.sv
// Paged two-wire slave register port with one/two byte offsets
`timescale 1ns/10ps
`include "psrp_regs.svh"

// Contract
// - Port serves host accesses only after reset sequence completes.
// - Port settings may change at any time, taken from settings input.
// - 16-bit offset space; only upper 32KB reaches user registers.
// - Port keeps own page register for paged offsets.
// - Standard start, stop, address, acknowledge and data transfer.
// - Base address register loadable, default 1011000b.
// - Address bits 0 and 1 follow two static pins.
// - Address bit 2 optionally defaults from a reset-time strap.
// - Respond only to combined base address.
// - Two-wire mode selects one-byte or two-byte offsets.
// - All offset bits address registers; direction rides address byte.
// - One-byte mode: page high byte plus offset; 0xFC hits page register.
// - Two-byte mode: full 16-bit offset; page register at 0xFFFC.
// - Pointer advances by one after every data byte.
// - Works at 100kHz, 400kHz and 1MHz bus clocks.
// - Strap pins captured at rising edge of master reset.
module psrp_port (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        scl_pin,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        select_or_addr_bit0_pin,
  input  wire logic        serial_in_or_addr_bit1_pin,
  input  wire logic        master_reset_n,
  input  wire logic        addr_bit2_strap_pin,
  input  wire logic        addr_bit2_strap_en,
  input  wire logic        port_ready,
  input  wire logic [1:0]  port0_settings_field,
  input  wire logic        cfg_base_load,
  input  wire logic [6:0]  cfg_base_addr,
  output logic [15:0]      reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             reg_we,
  output logic             reg_re,
  input  wire logic [7:0]  reg_rdata,
  output logic [31:0]      register_page_select,
  output logic [6:0]       base_addr
);
  psrp_pkg::psrp_state_s q;
  psrp_pkg::psrp_state_s d;

  psrp_pin_if #(.W(`PSRP_SYNC_WIDTH)) pins ();

  assign pins.raw = {addr_bit2_strap_pin, master_reset_n, serial_in_or_addr_bit1_pin,
                     select_or_addr_bit0_pin, sda_in, scl_pin};

  psrp_sync #(
    .WIDTH   (`PSRP_SYNC_WIDTH),
    .RST_VAL (`PSRP_SYNC_IDLE)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .pins     (pins.sync_side)
  );

  logic       scl_s;
  logic       sda_s;
  logic       a0_s;
  logic       a1_s;
  logic       mr_s;
  logic       strap_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic       enabled;
  logic       two_byte;
  logic       page_hit;
  logic [6:0] dev_addr;
  logic [15:0] ptr_inc;

  assign scl_s    = pins.sync[0];
  assign sda_s    = pins.sync[1];
  assign a0_s     = pins.sync[2];
  assign a1_s     = pins.sync[3];
  assign mr_s     = pins.sync[4];
  assign strap_s  = pins.sync[5];
  assign scl_rise = scl_s && !q.prev_scl;
  assign scl_fall = !scl_s && q.prev_scl;
  // Start and stop only count while the clock stays high across both samples
  assign start_ev = scl_s && q.prev_scl && q.prev_sda && !sda_s;
  assign stop_ev  = scl_s && q.prev_scl && !q.prev_sda && sda_s;
  assign enabled  = port_ready && !port0_settings_field[`PSRP_SET_SPI_BIT];
  assign two_byte = port0_settings_field[`PSRP_SET_TWO_BYTE_BIT];
  assign dev_addr = {q.base[6:2], a1_s, a0_s};
  assign page_hit = (q.ptr[15:2] == `PSRP_PAGE_WORD_IDX);
  assign ptr_inc  = q.ptr + 16'h0001;

  always_comb begin
    d          = q;
    d.prev_scl = scl_s;
    d.prev_sda = sda_s;
    d.prev_mr  = mr_s;
    d.reg_we   = 1'b0;
    d.reg_re   = 1'b0;
    d.rd_pend  = 1'b0;
    d.sda_o    = 1'b0;

    // Strap caught on the release edge; a later configuration load wins
    if (mr_s && !q.prev_mr && addr_bit2_strap_en) begin
      d.base[2] = strap_s;
    end
    if (cfg_base_load) begin
      d.base = cfg_base_addr;
    end

    // Read data lands one cycle after the request
    if (q.rd_pend) begin
      if (page_hit) begin
        d.shift = q.page[{q.ptr[1:0], 3'h0} +: 8];
      end else if (q.ptr[`PSRP_USER_SPACE_BIT]) begin
        d.shift = reg_rdata;
      end else begin
        d.shift = 8'h00;
      end
    end

    if (!enabled) begin
      d.st       = psrp_pkg::ST_IDLE;
      d.sda_oe_n = 1'b1;
    end else if (stop_ev) begin
      d.st       = psrp_pkg::ST_IDLE;
      d.sda_oe_n = 1'b1;
    end else if (start_ev) begin
      // Repeated start keeps the pointer for the read that follows
      d.st       = psrp_pkg::ST_RX;
      d.kind     = psrp_pkg::K_ADDR;
      d.bitcnt   = 4'h0;
      d.sda_oe_n = 1'b1;
    end else begin
      unique case (q.st)
        psrp_pkg::ST_IDLE: begin
          d.sda_oe_n = 1'b1;
        end
        psrp_pkg::ST_RX: begin
          if (scl_rise && q.bitcnt != 4'h8) begin
            d.shift  = {q.shift[6:0], sda_s};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == 4'h8) begin
            d.st       = psrp_pkg::ST_ACK;
            d.sda_oe_n = 1'b0;
            unique case (q.kind)
              psrp_pkg::K_ADDR: begin
                if (q.shift[7:1] != dev_addr) begin
                  d.st       = psrp_pkg::ST_IDLE;
                  d.sda_oe_n = 1'b1;
                end else begin
                  d.rw = q.shift[0];
                  if (q.shift[0]) begin
                    d.rd_pend = 1'b1;
                    d.reg_re  = !page_hit && q.ptr[`PSRP_USER_SPACE_BIT];
                    d.reg_addr = q.ptr;
                  end
                end
              end
              psrp_pkg::K_OFS_HI: begin
                d.ptr[15:8] = q.shift;
              end
              psrp_pkg::K_OFS_LO: begin
                if (two_byte) begin
                  d.ptr[7:0] = q.shift;
                end else if (q.shift >= `PSRP_ONE_BYTE_PAGE) begin
                  d.ptr = {8'hFF, q.shift};
                end else begin
                  d.ptr = {q.page[`PSRP_PAGE_HI_LSB +: 8], q.shift};
                end
              end
              psrp_pkg::K_DATA: begin
                if (page_hit) begin
                  d.page[{q.ptr[1:0], 3'h0} +: 8] = q.shift;
                end else if (q.ptr[`PSRP_USER_SPACE_BIT]) begin
                  d.reg_we    = 1'b1;
                  d.reg_addr  = q.ptr;
                  d.reg_wdata = q.shift;
                end
                d.ptr = ptr_inc;
              end
            endcase
          end
        end
        psrp_pkg::ST_ACK: begin
          if (scl_fall) begin
            d.bitcnt = 4'h0;
            if (q.rw) begin
              d.st       = psrp_pkg::ST_TX;
              d.sda_oe_n = q.shift[7];
            end else begin
              d.st       = psrp_pkg::ST_RX;
              d.sda_oe_n = 1'b1;
              unique case (q.kind)
                psrp_pkg::K_ADDR:   d.kind = two_byte ? psrp_pkg::K_OFS_HI : psrp_pkg::K_OFS_LO;
                psrp_pkg::K_OFS_HI: d.kind = psrp_pkg::K_OFS_LO;
                default:            d.kind = psrp_pkg::K_DATA;
              endcase
            end
          end
        end
        psrp_pkg::ST_TX: begin
          if (scl_rise) begin
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == 4'h8) begin
            d.st       = psrp_pkg::ST_MACK;
            d.sda_oe_n = 1'b1;
            d.ptr      = ptr_inc;
          end else if (scl_fall) begin
            d.shift    = {q.shift[6:0], 1'b0};
            d.sda_oe_n = q.shift[6];
          end
        end
        psrp_pkg::ST_MACK: begin
          if (scl_rise) begin
            // Host acknowledge asks for the next byte; fetch it now
            d.cont = !sda_s;
            if (!sda_s) begin
              d.rd_pend  = 1'b1;
              d.reg_re   = !page_hit && q.ptr[`PSRP_USER_SPACE_BIT];
              d.reg_addr = q.ptr;
            end
          end else if (scl_fall) begin
            d.bitcnt   = 4'h0;
            d.st       = q.cont ? psrp_pkg::ST_TX : psrp_pkg::ST_IDLE;
            d.sda_oe_n = q.cont ? q.shift[7] : 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q          <= '0;
      q.st       <= psrp_pkg::ST_IDLE;
      q.kind     <= psrp_pkg::K_ADDR;
      q.page     <= `PSRP_PAGE_REG_RST;
      q.base     <= `PSRP_BASE_ADDR_DFLT;
      q.sda_oe_n <= 1'b1;
      q.prev_scl <= 1'b1;
      q.prev_sda <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign sda_out              = q.sda_o;
  assign sda_oe_n             = q.sda_oe_n;
  assign reg_addr             = q.reg_addr;
  assign reg_wdata            = q.reg_wdata;
  assign reg_we               = q.reg_we;
  assign reg_re               = q.reg_re;
  assign register_page_select = q.page;
  assign base_addr            = q.base;

  sequence s_mr_release;
    mr_s && !q.prev_mr && addr_bit2_strap_en && !cfg_base_load && clk_en;
  endsequence

  sequence s_addr_ack;
    q.st == psrp_pkg::ST_ACK && q.kind == psrp_pkg::K_ADDR && !q.rw;
  endsequence

  property p_idle_released;
    @(posedge core_clk) disable iff (!arst_n)
      q.st == psrp_pkg::ST_IDLE |-> q.sda_oe_n;
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("data line driven while idle");
  property p_user_space_only;
    @(posedge core_clk) disable iff (!arst_n)
      (q.reg_we || q.reg_re) |-> q.reg_addr[15] && q.reg_addr[15:2] != 14'h3FFF;
  endproperty
  a_user_space_only: assert property (p_user_space_only)
    else $error("register access outside user space");
  property p_ptr_advance;
    @(posedge core_clk) disable iff (!arst_n)
      q.reg_we |-> q.ptr == q.reg_addr + 16'h0001;
  endproperty
  a_ptr_advance: assert property (p_ptr_advance)
    else $error("pointer not advanced after write");
  property p_addr_match;
    @(posedge core_clk) disable iff (!arst_n)
      s_addr_ack |-> q.shift[7:1] == {q.base[6:2], a1_s, a0_s};
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("acknowledged a foreign address");
  property p_one_byte_page;
    @(posedge core_clk) disable iff (!arst_n)
      (q.st == psrp_pkg::ST_ACK && q.kind == psrp_pkg::K_OFS_LO && !two_byte &&
       q.shift < 8'hFC && $stable(two_byte)) |-> q.ptr == {q.page[15:8], q.shift};
  endproperty
  a_one_byte_page: assert property (p_one_byte_page)
    else $error("paged offset formed wrongly");
  property p_two_byte_low;
    @(posedge core_clk) disable iff (!arst_n)
      (q.st == psrp_pkg::ST_ACK && q.kind == psrp_pkg::K_OFS_LO && two_byte &&
       $stable(two_byte)) |-> q.ptr[7:0] == q.shift;
  endproperty
  a_two_byte_low: assert property (p_two_byte_low)
    else $error("full offset low byte wrong");
  property p_disabled_idle;
    @(posedge core_clk) disable iff (!arst_n)
      (!enabled && clk_en) |=> q.st == psrp_pkg::ST_IDLE && q.sda_oe_n;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("port active before ready");
  property p_ack_drives_low;
    @(posedge core_clk) disable iff (!arst_n)
      q.st == psrp_pkg::ST_ACK |-> !q.sda_oe_n && !q.sda_o;
  endproperty
  a_ack_drives_low: assert property (p_ack_drives_low)
    else $error("acknowledge bit not driven low");
  property p_strap_bit2;
    @(posedge core_clk) disable iff (!arst_n)
      s_mr_release |=> q.base[2] == $past(strap_s);
  endproperty
  a_strap_bit2: assert property (p_strap_bit2)
    else $error("address bit 2 strap not captured");
  property p_base_load;
    @(posedge core_clk) disable iff (!arst_n)
      (cfg_base_load && clk_en) |=> q.base == $past(cfg_base_addr);
  endproperty
  a_base_load: assert property (p_base_load)
    else $error("base address load lost");
endmodule : psrp_port

// File: design/psrp_regs.svh
// Register offsets, field positions, reset values for the paged two-wire slave port
`ifndef PSRP_REGS_SVH
`define PSRP_REGS_SVH

`define PSRP_BASE_ADDR_DFLT   7'h58
`define PSRP_PAGE_REG_OFS     16'hFFFC
`define PSRP_PAGE_REG_RST     32'h0000_0000
`define PSRP_PAGE_WORD_IDX    14'h3FFF
`define PSRP_ONE_BYTE_PAGE    8'hFC
`define PSRP_PAGE_HI_LSB      8
`define PSRP_USER_SPACE_BIT   15
`define PSRP_SET_SPI_BIT      0
`define PSRP_SET_TWO_BYTE_BIT 1
`define PSRP_SYNC_WIDTH       6
`define PSRP_SYNC_IDLE        6'h03

`endif

// File: design/psrp_pkg.sv
// Types shared by the paged two-wire slave port
package psrp_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } psrp_state_e;

  typedef enum logic [1:0] {
    K_ADDR   = 2'h0,
    K_OFS_HI = 2'h1,
    K_OFS_LO = 2'h2,
    K_DATA   = 2'h3
  } psrp_kind_e;

  typedef struct packed {
    psrp_state_e st;
    psrp_kind_e  kind;
    logic [3:0]  bitcnt;
    logic [7:0]  shift;
    logic        rw;
    logic        cont;
    logic [15:0] ptr;
    logic [31:0] page;
    logic [6:0]  base;
    logic        sda_oe_n;
    logic        sda_o;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_we;
    logic        reg_re;
    logic        rd_pend;
    logic        prev_scl;
    logic        prev_sda;
    logic        prev_mr;
  } psrp_state_s;

endpackage : psrp_pkg

// File: design/psrp_pin_if.sv
// Raw and synchronised pin bundle between the port and its synchroniser
`timescale 1ns/10ps
interface psrp_pin_if #(
  parameter int W = 6
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user (output raw, input sync);
endinterface : psrp_pin_if

// File: design/psrp_sync.sv
// Two-flop synchroniser for the pins of the slave port
`timescale 1ns/10ps
module psrp_sync #(
  parameter int               WIDTH   = 6,
  // Reset to the pins' idle levels so no false edge follows reset
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic     core_clk,
  input  wire logic     arst_n,
  input  wire logic     clk_en,
  psrp_pin_if.sync_side pins
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } psrp_sync_s;

  psrp_sync_s q;
  psrp_sync_s d;

  // First stage feeds only the second stage
  always_comb begin
    d    = q;
    d.s1 = pins.raw;
    d.s2 = q.s1;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= {RST_VAL, RST_VAL};
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign pins.sync = q.s2;
endmodule : psrp_sync

// File: testbench/psrp_host_model.sv
// Two-wire bus master model for the host side of the port
`timescale 1ns/10ps
module psrp_host_model (
  output logic     scl_pin,
  output logic     sda_drv,
  input wire logic sda_line
);
  // Clock stands high and data released outside frames
  initial begin
    scl_pin = 1'b1;
    sda_drv = 1'b1;
  end

  // Data set mid low phase, line sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    #50 sda_drv = b;
    #50 scl_pin = 1'b1;
    #50 s = sda_line;
    #50 scl_pin = 1'b0;
  endtask : bit_io

  // Also the repeated start of a read, no stop before it
  task automatic start();
    #50 sda_drv = 1'b1;
    #50 scl_pin = 1'b1;
    #100 sda_drv = 1'b0;
    #100 scl_pin = 1'b0;
  endtask : start

  task automatic stop();
    #50 sda_drv = 1'b0;
    #50 scl_pin = 1'b1;
    #100 sda_drv = 1'b1;
    #100;
  endtask : stop

  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : wr

  // Host acknowledges every byte but the last
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask : rd
endmodule : psrp_host_model

// File: testbench/testbench.sv
// Self-checking bench for the paged two-wire slave port
`timescale 1ns/10ps
module testbench;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        scl_pin;
  logic        sda_drv;
  wire logic   sda_in;
  logic        sda_out;
  logic        sda_oe_n;
  logic        select_or_addr_bit0_pin = 1'b1;
  logic        serial_in_or_addr_bit1_pin = 1'b1;
  logic        master_reset_n = 1'b0;
  logic        addr_bit2_strap_pin = 1'b1;
  logic        addr_bit2_strap_en = 1'b0;
  logic        port_ready = 1'b0;
  logic [1:0]  port0_settings_field = 2'h2; // Mode set from reset
  logic        cfg_base_load = 1'b0;
  logic [6:0]  cfg_base_addr = 7'h20;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_we;
  logic        reg_re;
  logic [31:0] register_page_select;
  logic [6:0]  base_addr;
  logic [7:0]  mem [0:255];
  logic [23:0] wlog [$];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic        ack;
  logic [7:0]  rd_byte;

  // Pull-up wire: either party pulls low
  assign sda_in = sda_drv & (sda_oe_n | sda_out);
  // Data only while the read strobe stands, so a lost strobe shows up
  assign reg_rdata = reg_re ? mem[reg_addr[7:0]] : 8'hEE;

  always #12.5 core_clk = ~core_clk;

  psrp_port psrp_port_inst (
    .core_clk, .arst_n, .clk_en, .scl_pin, .sda_in, .sda_out, .sda_oe_n,
    .select_or_addr_bit0_pin, .serial_in_or_addr_bit1_pin, .master_reset_n,
    .addr_bit2_strap_pin, .addr_bit2_strap_en, .port_ready, .port0_settings_field,
    .cfg_base_load, .cfg_base_addr, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .register_page_select, .base_addr
  );

  psrp_host_model psrp_host_model_inst (
    .scl_pin,
    .sda_drv,
    .sda_line (sda_in)
  );

  always @(posedge core_clk) begin
    if (reg_we === 1'b1) begin
      mem[reg_addr[7:0]] <= reg_wdata;
      wlog.push_back({reg_addr, reg_wdata});
    end
    cyc <= cyc + 1;
    // Tests need about 4300 cycles
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic wb(input logic [7:0] d, input logic nak);
    psrp_host_model_inst.wr(d, ack);
    chk(ack, nak);
  endtask : wb

  // Whole registers go in one burst
  task automatic burst(input logic [7:0] q[$]);
    psrp_host_model_inst.start();
    foreach (q[i]) wb(q[i], 1'b0);
  endtask : burst

  task automatic fin();
    psrp_host_model_inst.stop();
  endtask : fin

  task automatic probe(input logic [7:0] a, input logic nak);
    psrp_host_model_inst.start();
    wb(a, nak);
    fin();
  endtask : probe

  task automatic rb(input logic last, input logic [7:0] e);
    psrp_host_model_inst.rd(last, rd_byte);
    chk(rd_byte, e);
  endtask : rb

  task automatic wchk(input logic [23:0] e);
    chk(wlog.size() > 0 ? wlog.pop_front() : 24'h000000, e);
  endtask : wchk

  initial begin
    step(4);
    arst_n = 1'b1;
    master_reset_n = 1'b1;
    step(6);
    chk(base_addr, 7'h58);
    chk(register_page_select, 32'h0000_0000);
    chk(sda_oe_n, 1'b1);
    probe(8'hB6, 1'b1);
    port_ready = 1'b1;
    port0_settings_field = 2'h3;
    probe(8'hB6, 1'b1);
    port0_settings_field = 2'h2;
    probe(8'hB4, 1'b1);
    burst('{8'hB6, 8'hFF, 8'hFC, 8'h11, 8'h22, 8'h33, 8'h44});
    fin();
    chk(register_page_select, 32'h4433_2211);
    burst('{8'hB6, 8'hC0, 8'h24, 8'hA1, 8'hA2});
    fin();
    wchk(24'hC024A1);
    wchk(24'hC025A2);
    burst('{8'hB6, 8'hC0, 8'h24});
    burst('{8'hB7});
    rb(1'b0, 8'hA1);
    rb(1'b1, 8'hA2);
    fin();
    burst('{8'hB6, 8'h12, 8'h34, 8'h5A});
    fin();
    chk(wlog.size(), 0);
    burst('{8'hB6, 8'h12, 8'h34});
    burst('{8'hB7});
    rb(1'b1, 8'h00);
    fin();
    port0_settings_field = 2'h0;
    burst('{8'hB6, 8'hFC, 8'h00, 8'hCB, 8'h10, 8'h20});
    fin();
    chk(register_page_select, 32'h2010_CB00);
    burst('{8'hB6, 8'hFC});
    burst('{8'hB7});
    rb(1'b0, 8'h00);
    rb(1'b1, 8'hCB);
    fin();
    // Stays inside the current page
    burst('{8'hB6, 8'hE4, 8'h50});
    fin();
    wchk(24'hCBE450);
    burst('{8'hB6, 8'hE4});
    burst('{8'hB7});
    rb(1'b1, 8'h50);
    fin();
    addr_bit2_strap_en = 1'b1;
    master_reset_n = 1'b0;
    step(4);
    master_reset_n = 1'b1;
    step(6);
    chk(base_addr, 7'h5C);
    probe(8'hB6, 1'b1);
    probe(8'hBE, 1'b0);
    // Pins only change between frames
    select_or_addr_bit0_pin = 1'b0;
    probe(8'hBC, 1'b0);
    serial_in_or_addr_bit1_pin = 1'b0;
    probe(8'hB8, 1'b0);
    // Frozen clock enable must swallow the load
    clk_en = 1'b0;
    cfg_base_load = 1'b1;
    step(2);
    chk(base_addr, 7'h5C);
    cfg_base_load = 1'b0;
    clk_en = 1'b1;
    step(1);
    cfg_base_load = 1'b1;
    step(1);
    cfg_base_load = 1'b0;
    step(1);
    chk(base_addr, 7'h20);
    probe(8'h40, 1'b0);
    test_done();
  end
endmodule : testbench
